//--- inc/iess_pkg.sv
// Package with register map, field positions and reset values of the interrupt enable/edge/shared block
package iess_pkg;
	// Printed offsets are not all multiples of four: they are register indices, byte address is index * 4
	localparam logic [11:0] IDX_PORTC_ENH = 12'hfc7;
	localparam logic [11:0] IDX_PORTC_ENL = 12'hfc8;
	localparam logic [11:0] IDX_EDGE_SEL = 12'hfcd;
	localparam logic [11:0] IDX_SHARED_SEL = 12'hfce;
	localparam logic [11:0] IDX_MASTER_CTL = 12'hfcf;
	// Own registers for pending status and interrupt mask
	localparam logic [11:0] IDX_PEND_STAT = 12'hfd0;
	localparam logic [11:0] IDX_PEND_MASK = 12'hfd1;
	localparam int ADDR_W = 14;
	localparam int REQ_N = 14;
	localparam int PORTC_LSB = 0;
	localparam int PORTA_LSB = 4;
	localparam int PORTC_N = 4;
	localparam int PORTA_N = 8;
	localparam int GLOBAL_EN_BIT = 7;
	localparam int VOLT_SEL_BIT = 7;
	localparam int COMP_SEL_BIT = 6;
	localparam logic [3:0] PORTC_MASK = 4'hf;
	localparam logic [7:0] SHARED_MASK = 8'hc0;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [REQ_N-1:0] MASK_RESET = 14'h0000;
	localparam logic [1:0] LVL_OFF = 2'h0;
endpackage : iess_pkg

//--- core/iess_edge_detect.sv
// Edge detector with per-bit polarity selection
`timescale 1ns/100ps
module iess_edge_detect #(
	parameter int WIDTH = 8 // Number of inputs
) (
	input wire logic mclk, // 200 MHz clock
	input wire logic rst, // Synchronous reset
	input wire logic [WIDTH-1:0] level, // Synchronised levels
	input wire logic [WIDTH-1:0] rising, // 1 rising, 0 falling
	output logic [WIDTH-1:0] edgeHit // One-cycle edge pulse
);
	logic [WIDTH-1:0] prev;

	// Previous level held for comparison
	always_ff @(posedge mclk)
	begin
		if (rst)
			prev <= '0;
		else
			prev <= level;
	end

	// Selected polarity edge
	always_comb
	begin
		for (int i = 0; i < WIDTH; i++)
			edgeHit[i] = rising[i] ? (level[i] & ~prev[i]) : (~level[i] & prev[i]);
	end
endmodule : iess_edge_detect

//--- core/iess_irq_ctrl.sv
// Interrupt enable, edge select, shared source select and master enable with APB access
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
module iess_irq_ctrl
	import iess_pkg::*;
(
	input wire logic mclk, // 200 MHz system clock
	input wire logic rst, // Synchronous reset, high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [iess_pkg::ADDR_W-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic [7:0] portaPin, // Port A pins, asynchronous
	input wire logic [3:0] portcPinRequest, // Port C request pulses, same clock
	input wire logic lowVoltageDetector, // Voltage detector level, asynchronous
	input wire logic comparatorOut, // Comparator level, asynchronous
	input wire logic enableInstr, // Enable-interrupts instruction pulse
	input wire logic returnInstr, // Return-from-interrupt instruction pulse
	input wire logic disableInstr, // Disable-interrupts instruction pulse
	input wire logic cpuAck, // Processor acknowledges forwarded request
	output logic cpuReq, // Request to processor
	output logic [3:0] cpuReqId, // Index of forwarded request
	output logic [1:0] cpuReqLevel, // Level of forwarded request
	output logic [13:0] pendingOut, // Pending bits, port A 11..4, port C 3..0
	output logic irq // Level interrupt from status and mask
);
	typedef struct packed {
		logic [3:0] enh;
		logic [3:0] enl;
		logic [7:0] edgeSel;
		logic [1:0] sharedSel;
		logic globalEn;
		logic [REQ_N-1:0] pend;
		logic [REQ_N-1:0] mask;
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [1:0] anaSync1;
		logic [1:0] anaSync2;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic req;
		logic [3:0] reqId;
		logic [1:0] reqLevel;
		logic intOut;
	} iess_state_s;

	iess_state_s cur;
	iess_state_s next_cur;
	logic [7:0] srcLevel;
	logic [7:0] portaRise;
	logic [7:0] portaEdge;
	logic [REQ_N-1:0] arrive;
	logic [REQ_N-1:0] lvlHi;
	logic [REQ_N-1:0] lvlLo;
	logic [11:0] index;
	logic rdStrobe;
	logic wrStrobe;
	logic setup;
	logic [1:0] bestLvl;
	logic [3:0] bestId;

	// Decode of an enable pair into a level, 00 meaning off
	function automatic logic [1:0] iess_level(input logic hi, input logic lo);
		iess_level = {hi, lo};
	endfunction : iess_level

	// Mapped index check
	function automatic logic iess_mapped(input logic [11:0] idx);
		iess_mapped = idx == IDX_PORTC_ENH || idx == IDX_PORTC_ENL || idx == IDX_EDGE_SEL
			|| idx == IDX_SHARED_SEL || idx == IDX_MASTER_CTL || idx == IDX_PEND_STAT
			|| idx == IDX_PEND_MASK;
	endfunction : iess_mapped

	// Shared sources chosen before edge detection so that a switch can make an edge
	always_comb
	begin
		srcLevel = cur.sync2;
		srcLevel[VOLT_SEL_BIT] = cur.sharedSel[1] ? cur.anaSync2[0] : cur.sync2[VOLT_SEL_BIT];
		srcLevel[COMP_SEL_BIT] = cur.sharedSel[0] ? cur.anaSync2[1] : cur.sync2[COMP_SEL_BIT];
		portaRise = cur.edgeSel;
	end

	iess_edge_detect #(
		.WIDTH(PORTA_N)
	) u_edge (
		.mclk(mclk),
		.rst(rst),
		.level(srcLevel),
		.rising(portaRise),
		.edgeHit(portaEdge)
	);

	// Per-request levels; port A levels come from other enable registers outside this block, taken as level 1
	always_comb
	begin
		lvlHi = '0;
		lvlLo = '0;
		lvlHi[PORTC_N-1:0] = cur.enh;
		lvlLo[PORTC_N-1:0] = cur.enl;
		lvlLo[REQ_N-1:PORTA_LSB] = '1;
		arrive = '0;
		arrive[PORTC_N-1:0] = portcPinRequest;
		arrive[PORTA_LSB +: PORTA_N] = portaEdge;
	end

	// Highest level pending request, lowest index wins a tie
	always_comb
	begin
		bestLvl = LVL_OFF;
		bestId = 4'h0;
		for (int i = REQ_N - 1; i >= 0; i--)
		begin
			if (cur.pend[i] && iess_level(lvlHi[i], lvlLo[i]) != LVL_OFF
				&& iess_level(lvlHi[i], lvlLo[i]) >= bestLvl)
			begin
				bestLvl = iess_level(lvlHi[i], lvlLo[i]);
				bestId = 4'(i);
			end
		end
	end

	// APB strobes: answer in the access cycle, zero wait states
	always_comb
	begin
		index = paddr[ADDR_W-1:2];
		setup = psel & ~penable;
		rdStrobe = psel & penable & ~pwrite;
		wrStrobe = psel & penable & pwrite & iess_mapped(index);
	end

	// Next state
	always_comb
	begin
		next_cur = cur;
		next_cur.sync1 = portaPin;
		next_cur.sync2 = cur.sync1;
		// Detector and comparator levels are asynchronous too: same two-stage path as the pins
		next_cur.anaSync1 = {comparatorOut, lowVoltageDetector};
		next_cur.anaSync2 = cur.anaSync1;
		next_cur.ready = setup;
		next_cur.err = setup & ~iess_mapped(index);
		next_cur.rdata = 32'h0000_0000;
		if (setup && !pwrite)
		begin
			case (index)
				IDX_PORTC_ENH: next_cur.rdata[3:0] = cur.enh;
				IDX_PORTC_ENL: next_cur.rdata[3:0] = cur.enl;
				IDX_EDGE_SEL: next_cur.rdata[7:0] = cur.edgeSel;
				IDX_SHARED_SEL: next_cur.rdata[7:6] = cur.sharedSel;
				IDX_MASTER_CTL: next_cur.rdata[GLOBAL_EN_BIT] = cur.globalEn;
				IDX_PEND_STAT: next_cur.rdata[REQ_N-1:0] = cur.pend;
				IDX_PEND_MASK: next_cur.rdata[REQ_N-1:0] = cur.mask;
				default: next_cur.rdata = 32'h0000_0000;
			endcase
		end
		// Register writes; reserved bits dropped
		if (wrStrobe)
		begin
			case (index)
				IDX_PORTC_ENH: next_cur.enh = pwdata[3:0] & PORTC_MASK;
				IDX_PORTC_ENL: next_cur.enl = pwdata[3:0] & PORTC_MASK;
				IDX_EDGE_SEL: next_cur.edgeSel = pwdata[7:0];
				IDX_SHARED_SEL: next_cur.sharedSel = pwdata[7:6];
				IDX_MASTER_CTL: next_cur.globalEn = pwdata[GLOBAL_EN_BIT];
				IDX_PEND_MASK: next_cur.mask = pwdata[REQ_N-1:0];
				default: next_cur.mask = cur.mask;
			endcase
		end
		// Instructions and acknowledge override a same-cycle write
		if (enableInstr || returnInstr)
			next_cur.globalEn = 1'b1;
		if (disableInstr || cpuAck)
			next_cur.globalEn = 1'b0;
		// Reading the status clears only the bits that the read returned: a request that lands
		// at the setup edge missed the snapshot and must survive; new arrivals win over the clear
		if (rdStrobe && index == IDX_PEND_STAT)
			next_cur.pend = cur.pend & ~cur.rdata[REQ_N-1:0];
		if (cpuAck && cur.req)
			next_cur.pend[cur.reqId] = 1'b0;
		next_cur.pend = next_cur.pend | arrive;
		// Forward only when globally enabled; disabled requests stay pending
		next_cur.req = cur.globalEn && !cpuAck && bestLvl != LVL_OFF;
		next_cur.reqId = bestId;
		next_cur.reqLevel = bestLvl;
		next_cur.intOut = |(next_cur.pend & next_cur.mask);
	end

	// State register
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			cur <= '0;
			cur.mask <= MASK_RESET;
		end
		else
			cur <= next_cur;
	end

	// Outputs straight from state flops
	assign prdata = cur.rdata;
	assign pready = cur.ready;
	assign pslverr = cur.err;
	assign cpuReq = cur.req;
	assign cpuReqId = cur.reqId;
	assign cpuReqLevel = cur.reqLevel;
	assign pendingOut = cur.pend;
	assign irq = cur.intOut;

	// Enable instruction raises the global enable next cycle
	enable_set_a: assert property (@(posedge mclk) disable iff (rst)
		(enableInstr || returnInstr) && !disableInstr && !cpuAck |=> cur.globalEn)
		else $error("global enable not set");

	// Acknowledge or disable clears it
	enable_clear_a: assert property (@(posedge mclk) disable iff (rst)
		disableInstr || cpuAck |=> !cur.globalEn)
		else $error("global enable not cleared");

	// No forwarding while globally disabled
	req_gated_a: assert property (@(posedge mclk) disable iff (rst)
		!$past(cur.globalEn) |-> !cpuReq)
		else $error("request forwarded while disabled");

	// Arrival sets pending
	pend_set_a: assert property (@(posedge mclk) disable iff (rst)
		arrive[0] |=> pendingOut[0])
		else $error("pending bit not set");

	// Forwarded request always has nonzero level
	req_level_a: assert property (@(posedge mclk) disable iff (rst)
		cpuReq |-> cpuReqLevel != LVL_OFF)
		else $error("disabled request forwarded");

	// Port C high enable reads keep reserved bits zero
	portc_read_a: assert property (@(posedge mclk) disable iff (rst)
		$past(setup && !pwrite && index == IDX_PORTC_ENH) |-> prdata[31:4] == 28'h0000000)
		else $error("reserved bits not zero");

	// Falling edge on pin 0 with polarity 0 raises a request
	fall_edge_a: assert property (@(posedge mclk) disable iff (rst)
		!cur.edgeSel[0] && $fell(srcLevel[0]) |-> portaEdge[0])
		else $error("falling edge missed");

	// Shared source switch with stable levels can itself produce an edge
	shared_edge_a: assert property (@(posedge mclk) disable iff (rst)
		cur.edgeSel[7] && $rose(srcLevel[7]) |-> arrive[11])
		else $error("shared edge missed");

	// Checks below look at one representative bit where the logic is the same for every bit

	// Pending level-3 request is forwarded at level 3
	top_level_a: assert property (@(posedge mclk) disable iff (rst)
		$past(cur.globalEn && !cpuAck && cur.pend[2] && cur.enh[2] && cur.enl[2]) |-> cpuReq && cpuReqLevel == 2'h3)
		else $error("level three request not forwarded");

	// A request with pair 00 is never forwarded
	off_pair_a: assert property (@(posedge mclk) disable iff (rst)
		$past(cur.pend[3] && !cur.enh[3] && !cur.enl[3]) |-> !(cpuReq && cpuReqId == 4'h3))
		else $error("disabled request forwarded");

	// A disabled request stays pending until software reads it away
	off_pend_a: assert property (@(posedge mclk) disable iff (rst)
		cur.pend[3] && !cur.enh[3] && !cur.enl[3] && !rdStrobe && !(cpuAck && cur.reqId == 4'h3) |=> cur.pend[3])
		else $error("disabled request lost");

	// Rising edge with polarity 1 raises a request
	rise_edge_a: assert property (@(posedge mclk) disable iff (rst)
		cur.edgeSel[0] && $rose(srcLevel[0]) |-> portaEdge[0])
		else $error("rising edge missed");

	// Rising edge with polarity 0 raises nothing
	no_edge_a: assert property (@(posedge mclk) disable iff (rst)
		!cur.edgeSel[1] && $rose(srcLevel[1]) |-> !portaEdge[1])
		else $error("wrong edge taken");

	// Shared request 7 follows its pin through two flops while the pin is selected
	pin7_path_a: assert property (@(posedge mclk) disable iff (rst)
		!$past(rst) && !$past(rst, 2) && !cur.sharedSel[1] |-> srcLevel[VOLT_SEL_BIT] == $past(portaPin[VOLT_SEL_BIT], 2))
		else $error("pin seven path wrong");

	// Shared request 7 follows the voltage detector when selected
	volt_path_a: assert property (@(posedge mclk) disable iff (rst)
		!$past(rst) && !$past(rst, 2) && cur.sharedSel[1] |-> srcLevel[VOLT_SEL_BIT] == $past(lowVoltageDetector, 2))
		else $error("detector path wrong");

	// Shared request 6 follows the comparator when selected
	comp_path_a: assert property (@(posedge mclk) disable iff (rst)
		!$past(rst) && !$past(rst, 2) && cur.sharedSel[0] |-> srcLevel[COMP_SEL_BIT] == $past(comparatorOut, 2))
		else $error("comparator path wrong");

	// Control register reads the enable in bit 7 and zero below and above
	master_read_a: assert property (@(posedge mclk) disable iff (rst)
		$past(setup && !pwrite && index == IDX_MASTER_CTL) |-> prdata == {24'h000000, $past(cur.globalEn), 7'h00})
		else $error("control register read wrong");

	// Writing one sets the enable
	write_one_a: assert property (@(posedge mclk) disable iff (rst)
		wrStrobe && index == IDX_MASTER_CTL && pwdata[GLOBAL_EN_BIT] && !disableInstr && !cpuAck |=> cur.globalEn)
		else $error("write one did not enable");

	// Writing zero clears the enable
	write_zero_a: assert property (@(posedge mclk) disable iff (rst)
		wrStrobe && index == IDX_MASTER_CTL && !pwdata[GLOBAL_EN_BIT] && !enableInstr && !returnInstr
		|=> !cur.globalEn)
		else $error("write zero did not disable");

	// Pending bits are sticky until read or acknowledged
	pend_hold_a: assert property (@(posedge mclk) disable iff (rst)
		cur.pend[4] && !rdStrobe && !(cpuAck && cur.reqId == 4'h4) |=> cur.pend[4])
		else $error("pending bit dropped");

	// Interrupt line mirrors unmasked pending bits
	irq_level_a: assert property (@(posedge mclk) disable iff (rst)
		irq == |(cur.pend & cur.mask))
		else $error("interrupt line wrong");

	// Unmapped index answers with an error in the access cycle
	unmapped_err_a: assert property (@(posedge mclk) disable iff (rst)
		$past(setup && !iess_mapped(index)) |-> pready && pslverr)
		else $error("unmapped access not refused");

	// Ready stands for one cycle only
	ready_pulse_a: assert property (@(posedge mclk) disable iff (rst)
		pready |=> !pready)
		else $error("ready held too long");

	// No answer without a select
	idle_ready_a: assert property (@(posedge mclk) disable iff (rst)
		!psel |=> !pready)
		else $error("ready without select");
endmodule : iess_irq_ctrl

//--- verification/iess_cpu_model.sv
// Processor core model that acknowledges forwarded requests
`timescale 1ns/100ps
module iess_cpu_model (
	input wire logic mclk, // System clock
	input wire logic rst, // Sync reset
	input wire logic cpuReq, // Request from block
	input wire logic [3:0] cpuReqId, // Forwarded index
	input wire logic [1:0] cpuReqLevel, // Forwarded level
	input wire logic [3:0] ackWait, // Cycles before ack, two or more
	output logic cpuAck, // One-cycle ack
	output logic [3:0] gotId, // Index taken at ack
	output logic [1:0] gotLevel, // Level taken at ack
	output int ackCount // Acks given
);
	logic [3:0] waitCnt;
	// Count restarts after each ack, so a request that falls late is not taken twice
	always @(posedge mclk)
	begin
		cpuAck <= 1'b0;
		if (rst)
			ackCount <= 0;
		if (rst || !cpuReq || cpuAck)
			waitCnt <= 4'h0;
		else if (waitCnt == ackWait)
		begin
			cpuAck <= 1'b1;
			gotId <= cpuReqId;
			gotLevel <= cpuReqLevel;
			ackCount <= ackCount + 1;
		end
		else
			waitCnt <= waitCnt + 4'h1;
	end
endmodule : iess_cpu_model

//--- verification/test_iess_irq_ctrl.sv
// Self-checking bench for the interrupt enable, edge and shared select block
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module test_iess_irq_ctrl;
	import iess_pkg::*;
	logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pslverr, pready, cpuReq, cpuAck, irq, err;
	logic lowVoltageDetector = 0, comparatorOut = 0;
	logic [13:0] paddr = 0, pendingOut;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [7:0] portaPin = 0;
	logic [3:0] portcPinRequest = 0, cpuReqId, gotId, ackWait = 4'h2;
	logic [2:0] instr = 0;
	logic [1:0] cpuReqLevel, gotLevel;
	int num_errors = 0, tests_run = 0, cycles = 0, acks;
	always #2.5 mclk = ~mclk;
	iess_irq_ctrl dut_u (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .portaPin(portaPin),
		.portcPinRequest(portcPinRequest), .lowVoltageDetector(lowVoltageDetector), .comparatorOut(comparatorOut),
		.enableInstr(instr[2]), .returnInstr(instr[1]), .disableInstr(instr[0]), .cpuAck(cpuAck), .cpuReq(cpuReq),
		.cpuReqId(cpuReqId), .cpuReqLevel(cpuReqLevel), .pendingOut(pendingOut), .irq(irq));
	iess_cpu_model cpu_u (.mclk(mclk), .rst(rst), .cpuReq(cpuReq), .cpuReqId(cpuReqId), .cpuReqLevel(cpuReqLevel),
		.ackWait(ackWait), .cpuAck(cpuAck), .gotId(gotId), .gotLevel(gotLevel), .ackCount(acks));
	// One APB transfer; the answer is awaited, not assumed
	task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do
			@(posedge mclk);
		while (pready !== 1'b1 && ++n < 20);
		if (pready !== 1'b1)
		begin
			num_errors++;
			$display("BAD %0t no ready", $time);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		`CHK({err, rd}, {1'b0, exp})
	endtask : rdchk
	task automatic pulse(input logic [2:0] v);
		@(posedge mclk);
		instr <= v;
		@(posedge mclk);
		instr <= 3'h0;
	endtask : pulse
	// Fixed wait covers the pin synchroniser and the edge stage
	task automatic waitPend(input int b, input logic e);
		repeat (8) @(posedge mclk);
		`CHK(pendingOut[b], e)
	endtask : waitPend
	task automatic waitAck(input logic [3:0] id, input logic [1:0] lvl);
		int n;
		n = acks + 1;
		repeat (40) if (acks < n) @(posedge mclk);
		`CHK({acks == n, gotId, gotLevel}, {1'b1, id, lvl})
	endtask : waitAck
	task automatic t_regs;
		rdchk(IDX_PORTC_ENH, 0);
		rdchk(IDX_PORTC_ENL, 0);
		rdchk(IDX_EDGE_SEL, 0);
		rdchk(IDX_SHARED_SEL, 0);
		rdchk(IDX_MASTER_CTL, 0);
		rdchk(IDX_PEND_MASK, 0);
		apb(1'b1, IDX_MASTER_CTL, 32'hff);
		rdchk(IDX_MASTER_CTL, 32'h80);
		apb(1'b1, IDX_MASTER_CTL, 32'h00);
		rdchk(IDX_MASTER_CTL, 0);
		apb(1'b1, 12'hfc0, 32'h5a);
		`CHK({err, rd}, {1'b1, 32'h0})
	endtask : t_regs
	task automatic t_edge;
		apb(1'b1, IDX_EDGE_SEL, 32'h01);
		@(posedge mclk);
		portaPin <= 8'h03;
		waitPend(4, 1'b1);
		`CHK(pendingOut[5], 1'b0)
		portaPin <= 8'h00;
		waitPend(5, 1'b1);
		rdchk(IDX_PEND_STAT, 32'h30);
		repeat (2) @(posedge mclk);
		`CHK(pendingOut, 14'h0)
	endtask : t_edge
	// Pin 7 rising, all others falling
	task automatic t_shared;
		apb(1'b1, IDX_EDGE_SEL, 32'h80);
		portaPin <= 8'h41;
		waitPend(10, 1'b0);
		portaPin <= 8'hc0;
		waitPend(4, 1'b1);
		`CHK(pendingOut[11], 1'b1)
		rdchk(IDX_PEND_STAT, 32'h810);
		// Switch made while interrupts are globally off; the falling step on bit 6 still pends
		apb(1'b1, IDX_SHARED_SEL, 32'hc0);
		waitPend(10, 1'b1);
		`CHK(pendingOut[11], 1'b0)
		rdchk(IDX_PEND_STAT, 32'h400);
		portaPin <= 8'h00;
		lowVoltageDetector <= 1'b1;
		waitPend(11, 1'b1);
		`CHK(pendingOut[10], 1'b0)
		lowVoltageDetector <= 1'b0;
		comparatorOut <= 1'b1;
		repeat (8) @(posedge mclk);
		comparatorOut <= 1'b0;
		waitPend(10, 1'b1);
		rdchk(IDX_PEND_STAT, 32'hc00);
		apb(1'b1, IDX_SHARED_SEL, 32'h00);
	endtask : t_shared
	// C0 low, C1 medium, C2 high, C3 disabled
	task automatic t_prio;
		apb(1'b1, IDX_PORTC_ENH, 32'h06);
		apb(1'b1, IDX_PORTC_ENL, 32'h05);
		rdchk(IDX_PORTC_ENH, 32'h06);
		portcPinRequest <= 4'hf;
		@(posedge mclk);
		portcPinRequest <= 4'h0;
		waitPend(3, 1'b1);
		`CHK({cpuReq, pendingOut[3:0]}, 5'h0f)
		pulse(3'h4);
		waitAck(4'h2, 2'h3);
		rdchk(IDX_MASTER_CTL, 0);
		ackWait <= 4'h9;
		pulse(3'h2);
		waitAck(4'h1, 2'h2);
		apb(1'b1, IDX_MASTER_CTL, 32'h80);
		waitAck(4'h0, 2'h1);
		pulse(3'h4);
		pulse(3'h1);
		rdchk(IDX_MASTER_CTL, 0);
		`CHK({cpuReq, pendingOut[3:0]}, 5'h08)
	endtask : t_prio
	task automatic t_irq;
		apb(1'b1, IDX_PEND_MASK, 32'h8);
		repeat (2) @(posedge mclk);
		`CHK(irq, 1'b1)
		apb(1'b1, IDX_PEND_MASK, 32'h0);
		repeat (2) @(posedge mclk);
		`CHK(irq, 1'b0)
		apb(1'b1, IDX_PEND_MASK, 32'h8);
		rdchk(IDX_PEND_STAT, 32'h8);
		repeat (2) @(posedge mclk);
		`CHK(irq, 1'b0)
	endtask : t_irq
	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	initial
	begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		t_regs();
		t_edge();
		t_shared();
		t_prio();
		t_irq();
		test_done();
	end
	// Cuts a hang short well above the few hundred cycles the run needs
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			num_errors++;
			test_done();
		end
	end
endmodule : test_iess_irq_ctrl
